// File: rtl/arx_pkg.sv
// package for the address-detecting serial receiver
package arx_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BAUD = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  // control field positions
  localparam int CTRL_PORT_EN = 0;
  localparam int CTRL_CLOCKED = 1;
  localparam int CTRL_NINTH = 2;
  localparam int CTRL_ADDR = 3;
  localparam int CTRL_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int CTRL_IRQEN = 5;
  localparam int CTRL_HIGHRATE = 6;
  localparam int CTRL_WIDEDIV = 7;
  localparam int CTRL_ANALOG = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
  // status field positions
  localparam int ST_NINTH = 0;
  localparam int ST_FRAMING_ERROR_FLAG = 1;
  localparam int ST_OVERRUN_FLAG = 2;
  localparam int ST_IDLE = 3;
  localparam int ST_RXFLAG = 4;
  localparam int ST_COUNT = 5;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  // index of the last data bit for nine- and eight-bit characters
  localparam logic [3:0] LAST_BIT_NINE = 4'h8;
  localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  // prescale by divider mode: {wide, high}
  localparam logic [5:0] PRE_64 = 6'h3F;
  localparam logic [5:0] PRE_16 = 6'h0F;
  localparam logic [5:0] PRE_4 = 6'h03;
  localparam logic [3:0] OVS_HALF = 4'h7;
  localparam logic [3:0] OVS_FULL = 4'hF;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } arx_state_e;

  // one buffered character
  typedef struct packed {
    logic framing_error_flag;
    logic ninth;
    logic [7:0] data;
  } arx_char_s;
endpackage

// File: rtl/arx_tick_gen.sv
// baud tick generator: sixteen ticks per bit
`timescale 1ns/100ps
module arx_tick_gen (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  // configuration
  input wire logic enable,
  input wire logic restart,
  input wire logic highRate,
  input wire logic wideDiv,
  input wire logic [15:0] divider,
  // tick
  output logic tick
);
  logic [5:0] preCount;
  logic [15:0] divCount;
  logic [5:0] preMax;

  // prescale 64/16/16/4 selected by the two mode bits; one tick per prescale times (divider + 1), low divider byte only unless wideDiv
  always_comb begin
    if (wideDiv && highRate) begin
      preMax = arx_pkg::PRE_4;
    end else if (wideDiv || highRate) begin
      preMax = arx_pkg::PRE_16;
    end else begin
      preMax = arx_pkg::PRE_64;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || restart || !enable) begin
      preCount <= '0;
      divCount <= '0;
      tick <= 1'b0;
    end else if (clockEnable) begin
      tick <= 1'b0;
      if (preCount == preMax) begin
        preCount <= '0;
        if (divCount == (wideDiv ? divider : {8'h00, divider[7:0]})) begin
          divCount <= '0;
          tick <= 1'b1;
        end else begin
          divCount <= divCount + 16'h0001;
        end
      end else begin
        preCount <= preCount + 6'h01;
      end
    end
  end
endmodule // arx_tick_gen

// File: rtl/arx_receiver.sv
// address-detecting asynchronous receiver with APB register access
// Function
// - address mode: ninth bit one raises flag
// - interrupt only when flag and enable set
// - buffered character reports ninth bit, errors
// - data read returns low eight oldest
// - clearing continuous enable clears overrun
// - address mode off: accept characters whatever their ninth bit
// - third unread character sets overrun
// - buffer holds two characters with status
// - nine-bit address mode: ninth zero discarded silently
// - after overrun keep buffer, accept nothing
// - start confirmed at mid-bit, else abandon
`timescale 1ns/100ps
module arx_receiver (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line and request
  input wire logic receiveLine,
  output logic receiveIrq
);
  logic [arx_pkg::CTRL_W-1:0] control;
  logic [15:0] baudDivider;
  arx_pkg::arx_state_e state;
  arx_pkg::arx_char_s buffer [arx_pkg::BUF_DEPTH];
  logic rdPtr;
  logic [1:0] count;
  logic overrun;
  logic [3:0] tickCount;
  logic [3:0] bitIndex;
  logic [8:0] shiftReg;
  logic [2:0] votes;
  logic lineDelayed;
  logic baudTick;
  logic portOn;
  logic receiveOn;
  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic dataRead;
  logic charDone;
  logic charKeep;
  logic charAccept;
  logic popArmed;
  logic stopLevel;
  logic majority;
  logic [31:0] next_prdata;
  arx_pkg::arx_char_s topChar;

  function automatic logic hitAddr(input logic [7:0] addr, input logic [7:0] offset);
    hitAddr = (addr == offset);
  endfunction

  assign portOn = control[arx_pkg::CTRL_PORT_EN] && !control[arx_pkg::CTRL_CLOCKED];
  assign receiveOn = portOn && control[arx_pkg::CTRL_CONTINUOUS_RECEIVE_ENABLE];
  assign apbAccess = psel && penable && clockEnable;
  assign apbWrite = apbAccess && pwrite;
  assign apbRead = apbAccess && !pwrite;
  // pop only a character that the setup cycle already placed on prdata
  assign dataRead = apbRead && hitAddr(paddr, arx_pkg::OFF_DATA) && popArmed;
  assign topChar = buffer[rdPtr];
  assign majority = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
  assign stopLevel = majority;
  assign charDone = (state == arx_pkg::RX_STOP) && baudTick && (tickCount == arx_pkg::OVS_FULL);
  // address mode with nine-bit characters only keeps characters with ninth bit set
  assign charKeep = !(control[arx_pkg::CTRL_ADDR] && control[arx_pkg::CTRL_NINTH]
                      && !shiftReg[8]);
  // a read in the completing cycle frees the slot the new character takes
  assign charAccept = charDone && charKeep && !overrun
                      && (count != arx_pkg::BUF_FULL || dataRead);

  arx_tick_gen u_tick (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .enable(portOn),
    .restart(apbWrite && hitAddr(paddr, arx_pkg::OFF_BAUD)),
    .highRate(control[arx_pkg::CTRL_HIGHRATE]),
    .wideDiv(control[arx_pkg::CTRL_WIDEDIV]),
    .divider(baudDivider),
    .tick(baudTick)
  );

  // control registers
  always_ff @(posedge clock) begin
    if (reset) begin
      control <= arx_pkg::CTRL_RESET;
      baudDivider <= arx_pkg::BAUD_RESET;
    end else if (apbWrite) begin
      if (hitAddr(paddr, arx_pkg::OFF_CTRL)) begin
        control <= pwdata[arx_pkg::CTRL_W-1:0];
      end else if (hitAddr(paddr, arx_pkg::OFF_BAUD)) begin
        baudDivider <= pwdata[15:0];
      end
    end
  end

  // receive state machine
  always_ff @(posedge clock) begin
    if (reset || !receiveOn) begin
      state <= arx_pkg::RX_IDLE;
      tickCount <= '0;
      bitIndex <= '0;
      shiftReg <= '0;
      votes <= '0;
      lineDelayed <= 1'b1;
    end else if (clockEnable) begin
      lineDelayed <= receiveLine;
      if (baudTick) begin
        votes <= {votes[1:0], receiveLine};
      end
      case (state)
        arx_pkg::RX_IDLE: begin
          tickCount <= '0;
          // no new character while overrun stands
          if (lineDelayed && !receiveLine && !overrun) begin
            state <= arx_pkg::RX_START;
          end
        end
        arx_pkg::RX_START: begin
          if (baudTick) begin
            tickCount <= tickCount + 4'h1;
            if (tickCount == arx_pkg::OVS_HALF) begin
              tickCount <= '0;
              bitIndex <= '0;
              // mid-bit check; a high line abandons without error
              state <= receiveLine ? arx_pkg::RX_IDLE : arx_pkg::RX_DATA;
            end
          end
        end
        arx_pkg::RX_DATA: begin
          if (baudTick) begin
            tickCount <= tickCount + 4'h1;
            if (tickCount == arx_pkg::OVS_FULL) begin
              shiftReg <= control[arx_pkg::CTRL_NINTH] ? {majority, shiftReg[8:1]}
                                                       : {1'b0, majority, shiftReg[7:1]};
              bitIndex <= bitIndex + 4'h1;
              if (bitIndex == (control[arx_pkg::CTRL_NINTH] ? arx_pkg::LAST_BIT_NINE
                                                            : arx_pkg::LAST_BIT_EIGHT)) begin
                state <= arx_pkg::RX_STOP;
              end
            end
          end
        end
        arx_pkg::RX_STOP: begin
          if (baudTick) begin
            tickCount <= tickCount + 4'h1;
            if (tickCount == arx_pkg::OVS_FULL) begin
              state <= arx_pkg::RX_IDLE;
            end
          end
        end
        default: state <= arx_pkg::RX_IDLE;
      endcase
    end
  end

  // two-entry buffer and overrun
  always_ff @(posedge clock) begin
    if (reset || !portOn) begin
      rdPtr <= 1'b0;
      count <= '0;
      for (int i = 0; i < arx_pkg::BUF_DEPTH; i++) begin
        buffer[i] <= '0;
      end
    end else if (clockEnable) begin
      if (charAccept) begin
        buffer[rdPtr ^ count[0]] <= '{framing_error_flag: !stopLevel, ninth: shiftReg[8],
                                       data: shiftReg[7:0]};
      end
      if (dataRead) begin
        rdPtr <= ~rdPtr;
      end
      if (charAccept && !dataRead) begin
        count <= count + 2'h1;
      end else if (dataRead && !charAccept) begin
        count <= count - 2'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !receiveOn) begin
      overrun <= 1'b0;
    end else if (clockEnable && charDone && charKeep && count == arx_pkg::BUF_FULL
                 && !dataRead) begin
      overrun <= 1'b1;
    end
  end

  // apb read data and interrupt request
  always_comb begin
    next_prdata = '0;
    if (hitAddr(paddr, arx_pkg::OFF_CTRL)) begin
      next_prdata[arx_pkg::CTRL_W-1:0] = control;
    end else if (hitAddr(paddr, arx_pkg::OFF_BAUD)) begin
      next_prdata[15:0] = baudDivider;
    end else if (hitAddr(paddr, arx_pkg::OFF_STAT)) begin
      next_prdata[arx_pkg::ST_NINTH] = (count != 2'd0) && topChar.ninth;
      next_prdata[arx_pkg::ST_FRAMING_ERROR_FLAG] = (count != 2'd0) && topChar.framing_error_flag;
      next_prdata[arx_pkg::ST_OVERRUN_FLAG] = overrun;
      next_prdata[arx_pkg::ST_IDLE] = (state == arx_pkg::RX_IDLE);
      next_prdata[arx_pkg::ST_RXFLAG] = (count != 2'd0);
      next_prdata[arx_pkg::ST_COUNT +: 2] = count;
    end else if (hitAddr(paddr, arx_pkg::OFF_DATA)) begin
      next_prdata[7:0] = (count != 2'd0) ? topChar.data : 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      receiveIrq <= 1'b0;
      popArmed <= 1'b0;
    end else if (clockEnable) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(hitAddr(paddr, arx_pkg::OFF_CTRL)
                 || hitAddr(paddr, arx_pkg::OFF_BAUD) || hitAddr(paddr, arx_pkg::OFF_STAT)
                 || hitAddr(paddr, arx_pkg::OFF_DATA));
      if (psel && !penable) begin
        prdata <= next_prdata;
        popArmed <= hitAddr(paddr, arx_pkg::OFF_DATA) && (count != arx_pkg::BUF_EMPTY);
      end
      receiveIrq <= receiveOn && (count != 2'd0) && control[arx_pkg::CTRL_IRQEN];
    end
  end
endmodule // arx_receiver

// File: bench/arx_receiver_monitor.sv
// checker for the receiver bus and request outputs
`timescale 1ns/100ps
module arx_receiver_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial and request
  input wire logic receiveLine,
  input wire logic receiveIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic setup;
  logic irqOff;
  assign setup = psel && !penable && clockEnable;
  assign irqOff = psel && penable && pready && pwrite && paddr == arx_pkg::OFF_CTRL
    && !pwdata[arx_pkg::CTRL_IRQEN];
  chk_ready_follows:
    assert property (setup |=> pready) else $error("no ready after setup");
  chk_ready_single:
    assert property (pready && clockEnable |=> !pready) else $error("ready too long");
  chk_ready_unasked:
    assert property (!psel && clockEnable |=> !pready) else $error("ready unasked");
  chk_err_unmapped:
    assert property (setup && paddr > 8'h0C |=> pslverr) else $error("no slverr");
  chk_err_mapped:
    assert property (setup && paddr[1:0] == 2'h0 && paddr <= 8'h0C |=> !pslverr)
      else $error("slverr on register");
  chk_err_zero:
    assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
  chk_err_ready:
    assert property (pslverr |-> pready) else $error("slverr alone");
  chk_irq_masked:
    assert property (irqOff |-> ##[1:2] !receiveIrq) else $error("irq not masked");
  chk_irq_flag:
    assert property (pready && !pwrite && paddr == arx_pkg::OFF_STAT && receiveIrq
      |-> prdata[arx_pkg::ST_RXFLAG]) else $error("irq without flag");
  cover property (setup && paddr == arx_pkg::OFF_DATA);
  cover property ($rose(receiveIrq));
  cover property (pslverr);
endmodule // arx_receiver_monitor

bind arx_receiver arx_receiver_monitor u_monitor (.clock(clock), .reset(reset),
  .clockEnable(clockEnable), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .receiveLine(receiveLine), .receiveIrq(receiveIrq));

// File: bench/arx_line_model.sv
// remote transmitter on the shared receive line
`timescale 1ns/100ps
module arx_line_model #(
  parameter int BIT = 64
) (
  // clock
  input wire logic clock,
  // request
  input wire logic go,
  input wire logic [8:0] ch,
  input wire logic badStop,
  input wire logic glitch,
  // line
  output logic line,
  output logic busy
);
  logic [10:0] frame;
  integer k;
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (go) begin
        busy <= 1'b1;
        // start, nine bits lsb first, stop; a glitch is a short false start
        frame = {~badStop, ch, 1'b0};
        for (k = 0; k < (glitch ? 1 : 11); k++) begin
          line <= frame[k];
          repeat (glitch ? 8 : BIT) @(posedge clock);
        end
        line <= 1'b1;
        repeat (BIT) @(posedge clock);
        busy <= 1'b0;
      end
    end
  end
endmodule // arx_line_model

// File: bench/tb_arx_receiver.sv
// testbench for the address-detecting receiver
`timescale 1ns/100ps
module tb_arx_receiver;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic go = 1'b0;
  logic badStop = 1'b0;
  logic glitch = 1'b0;
  logic [8:0] ch = 9'h000;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, receiveLine, receiveIrq, busy, lastErr;
  integer num_errors = 0;
  integer compares = 0;
  arx_receiver dut (.clock(clock), .reset(reset), .clockEnable(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receiveLine(receiveLine), .receiveIrq(receiveIrq));
  arx_line_model #(.BIT(64)) partner (.clock(clock), .go(go), .ch(ch), .badStop(badStop),
    .glitch(glitch), .line(receiveLine), .busy(busy));
  initial begin
    forever #4 clock = ~clock;
  end
  task give_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rdata = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50) begin
      chk("pready", 32'h1, 32'h0);
      give_verdict;
    end
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdata);
  endtask
  task irq(input logic e);
    repeat (2) @(posedge clock);
    #1;
    chk("irq", {31'h0, e}, {31'h0, receiveIrq});
  endtask
  task send(input logic [8:0] c, input logic bs, input logic gl);
    integer i;
    @(posedge clock);
    go <= 1'b1;
    ch <= c;
    badStop <= bs;
    glitch <= gl;
    @(posedge clock);
    go <= 1'b0;
    for (i = 0; i < 2000; i++) begin
      @(posedge clock);
      #1;
      if (i > 2 && busy !== 1'b1) break;
    end
    if (i == 2000) begin
      chk("frame", 32'h1, 32'h0);
      give_verdict;
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rd("ctrl", arx_pkg::OFF_CTRL, 32'h0);
    chk("slverr", 32'h0, {31'h0, lastErr});
    rd("baud", arx_pkg::OFF_BAUD, 32'h0);
    rd("stat", arx_pkg::OFF_STAT, 32'h8);
    rd("unmapped", 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, lastErr});
    apb(1'b1, arx_pkg::OFF_BAUD, 32'h0);
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hC0);
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hC1);
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hE1);
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hE5);
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hED);
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hFD);
    rd("ctrl", arx_pkg::OFF_CTRL, 32'hFD);
    send(9'h0A5, 1'b0, 1'b0);
    rd("stat", arx_pkg::OFF_STAT, 32'h8);
    send(9'h000, 1'b0, 1'b1);
    rd("stat", arx_pkg::OFF_STAT, 32'h8);
    irq(1'b0);
    send(9'h1A5, 1'b0, 1'b0);
    irq(1'b1);
    rd("stat", arx_pkg::OFF_STAT, 32'h39);
    rd("data", arx_pkg::OFF_DATA, 32'hA5);
    irq(1'b0);
    // address mode off: three unread characters, then one more
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hF5);
    send(9'h033, 1'b0, 1'b0);
    send(9'h144, 1'b1, 1'b0);
    send(9'h066, 1'b0, 1'b0);
    send(9'h077, 1'b0, 1'b0);
    rd("stat", arx_pkg::OFF_STAT, 32'h5C);
    rd("data", arx_pkg::OFF_DATA, 32'h33);
    rd("stat", arx_pkg::OFF_STAT, 32'h3F);
    rd("data", arx_pkg::OFF_DATA, 32'h44);
    rd("stat", arx_pkg::OFF_STAT, 32'h0C);
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hE5);
    rd("stat", arx_pkg::OFF_STAT, 32'h8);
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hD5);
    send(9'h088, 1'b0, 1'b0);
    rd("stat", arx_pkg::OFF_STAT, 32'h38);
    irq(1'b0);
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hF5);
    irq(1'b1);
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hD5);
    irq(1'b0);
    rd("data", arx_pkg::OFF_DATA, 32'h88);
    // eight-bit characters: the ninth slot is taken as the stop bit
    apb(1'b1, arx_pkg::OFF_CTRL, 32'hF1);
    send(9'h05A, 1'b0, 1'b0);
    rd("stat", arx_pkg::OFF_STAT, 32'h3A);
    rd("data", arx_pkg::OFF_DATA, 32'h5A);
    give_verdict;
  end
endmodule // tb_arx_receiver
